// *** core/wem_pkg.sv ***
// constants, codes and state type for the weigh error monitor
// assumes a 100 MHz mclk and a signed converter result per update
package wem_pkg;
  localparam logic signed [33:0] WEM_DISP_MAX    = 34'sh0_0001_869f;
  localparam logic [33:0]        WEM_OVER_DIVS   = 34'h0_0000_0009;
  localparam logic signed [23:0] WEM_ADC_POS_MAX = 24'sh7fff00;
  localparam logic signed [23:0] WEM_ADC_NEG_MIN = 24'sh800100;
  localparam logic signed [24:0] WEM_ZERO_MAX    = 25'sh0200000;
  localparam logic signed [24:0] WEM_SPAN_MIN    = 25'sh0030000;
  localparam logic signed [24:0] WEM_SPAN_MAX    = 25'sh0200000;
  localparam logic [11:0]        WEM_EXC_MIN     = 12'h800;
  localparam logic [7:0]         WEM_STABLE_INDICATOR_UPD    = 8'hc8;
  localparam logic [3:0] WEM_CE_NONE      = 4'h0;
  localparam logic [3:0] WEM_CE_ZERO_HIGH = 4'h2;
  localparam logic [3:0] WEM_CE_ZERO_NEG  = 4'h3;
  localparam logic [3:0] WEM_CE_BAL_OVER  = 4'h4;
  localparam logic [3:0] WEM_CE_BAL_ZERO  = 4'h5;
  localparam logic [3:0] WEM_CE_SPAN_LOW  = 4'h6;
  localparam logic [3:0] WEM_CE_SPAN_NEG  = 4'h7;
  localparam logic [3:0] WEM_CE_SPAN_HIGH = 4'h8;
  localparam logic [3:0] WEM_CE_UNSTABLE  = 4'h9;
  localparam int unsigned WEM_CLK_HZ    = 100000000;
  localparam int unsigned WEM_DEFER_MIN = 2;
  localparam int unsigned WEM_MS_CYC    = WEM_CLK_HZ / 1000;
  localparam int unsigned WEM_DEFER_MS  = WEM_DEFER_MIN * 60 * 1000;
  typedef enum logic [1:0] {
    WEM_CAL_IDLE = 2'b00,
    WEM_CAL_WAIT = 2'b01
  } wem_cal_st_t;
endpackage

// *** core/wem_weigh_error_monitor.sv ***
// over-scale, calibration error, fault flags and nonvolatile commit scheduling
// assumes inputs synchronous to mclk; change inputs are one-cycle pulses
// Overview of operation
// - weight error output high while any over-scale condition is present
// - positive overload when converter result exceeds its positive limit
// - negative overload when converter result falls below its negative limit
// - net weight is gross minus tare before net comparison
// - net over flag when net weight exceeds 99999
// - capacity over flag when gross exceeds capacity plus nine divisions
// - gross over flag when gross weight exceeds 99999
// - each over-scale flag clears itself once its condition is gone
// - zero calibration: code 2 load too high, code 3 load negative
// - span calibration: code 4 balance above capacity, code 5 balance zero
// - span calibration: code 6 output low, 7 negative, 8 too high
// - calibration aborts with code 9 when weight never becomes stable
// - excitation error while excitation level is below its minimum
// - checksum checked at power-on and self-check, error on mismatch
// - memory check failure in self-check or operation raises memory error
// - write pending lit from commit request until nvm_write_busy drops; a deferral alone leaves it dark
// - front panel changes are committed immediately every time
// - external tare and zero tracking: first immediate, later after 2 minutes
// - link commands: first immediate, later after 2 minutes
// - calibration error is a 4-bit code 0 to 9, zero is no error
// - weight error also set by overloads and zero alarm
module wem_weigh_error_monitor
  import wem_pkg::*;
#(
  parameter int unsigned MS_CYC   = WEM_MS_CYC,
  parameter int unsigned DEFER_MS = WEM_DEFER_MS
) (
  input  wire logic               mclk,
  input  wire logic               rst,
  input  wire logic               adc_valid,
  input  wire logic signed [23:0] adc_raw,
  input  wire logic signed [31:0] gross_weight,
  input  wire logic signed [31:0] tare_weight,
  input  wire logic        [16:0] capacity,
  input  wire logic        [6:0]  scale_div,
  input  wire logic               zero_alarm,
  input  wire logic               stable_indicator,
  input  wire logic               cal_zero_start,
  input  wire logic               cal_span_start,
  input  wire logic        [16:0] cal_balance,
  input  wire logic        [11:0] exc_level,
  input  wire logic               selfcheck_req,
  input  wire logic               cksum_valid,
  input  wire logic        [15:0] cksum_calc,
  input  wire logic        [15:0] cksum_ref,
  input  wire logic               nvm_check_valid,
  input  wire logic               nvm_check_ok,
  input  wire logic               chg_panel,
  input  wire logic               chg_ext,
  input  wire logic               chg_link,
  input  wire logic               nvm_write_busy,
  output logic                    adc_pos_overload,
  output logic                    adc_neg_overload,
  output logic                    net_over_flag,
  output logic                    capacity_over_flag,
  output logic                    gross_over_flag,
  output logic                    weight_error,
  output logic             [3:0]  cal_error,
  output logic                    cal_busy,
  output logic                    cal_done,
  output logic signed      [23:0] zero_point,
  output logic                    excitation_error,
  output logic                    checksum_error,
  output logic                    memory_error,
  output logic                    write_pending,
  output logic                    nvm_write_start
);

  // over-scale
  logic signed [33:0] gross_w;
  logic signed [33:0] net_w;
  logic signed [33:0] cap_lim;
  logic [4:0]         ovr_q, ovr_d;
  logic               werr_q, werr_d;

  always_comb begin
    gross_w = 34'(gross_weight);
    net_w   = 34'(gross_weight) - 34'(tare_weight);
    cap_lim = signed'(34'(capacity) + 34'(scale_div) * WEM_OVER_DIVS);
    ovr_d   = ovr_q;
    if (adc_valid) begin
      ovr_d[0] = adc_raw > WEM_ADC_POS_MAX;
      ovr_d[1] = adc_raw < WEM_ADC_NEG_MIN;
      ovr_d[2] = net_w > WEM_DISP_MAX;
      ovr_d[3] = gross_w > cap_lim;
      ovr_d[4] = gross_w > WEM_DISP_MAX;
    end
    werr_d = (|ovr_d) | zero_alarm;
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      ovr_q  <= 5'h00;
      werr_q <= 1'b0;
    end else begin
      ovr_q  <= ovr_d;
      werr_q <= werr_d;
    end
  end

  assign adc_pos_overload   = ovr_q[0];
  assign adc_neg_overload   = ovr_q[1];
  assign net_over_flag      = ovr_q[2];
  assign capacity_over_flag = ovr_q[3];
  assign gross_over_flag    = ovr_q[4];
  assign weight_error       = werr_q;

  // calibration
  wem_cal_st_t        cal_st_q, cal_st_d;
  logic               span_q, span_d;
  logic [7:0]         wait_q, wait_d;
  logic [3:0]         cerr_q, cerr_d;
  logic               done_q, done_d;
  logic signed [23:0] zpt_q, zpt_d;
  logic signed [24:0] span_v;

  always_comb begin
    cal_st_d = cal_st_q;
    span_d   = span_q;
    wait_d   = wait_q;
    cerr_d   = cerr_q;
    zpt_d    = zpt_q;
    done_d   = 1'b0;
    span_v   = 25'(adc_raw) - 25'(zpt_q);
    unique case (cal_st_q)
      WEM_CAL_IDLE: begin
        if (cal_zero_start || cal_span_start) begin
          cerr_d   = WEM_CE_NONE;
          span_d   = cal_span_start && !cal_zero_start;
          wait_d   = 8'h00;
          cal_st_d = WEM_CAL_WAIT;
          if (cal_span_start && !cal_zero_start) begin
            if (cal_balance == 17'h00000) begin
              cerr_d   = WEM_CE_BAL_ZERO;
              done_d   = 1'b1;
              cal_st_d = WEM_CAL_IDLE;
            end else if (cal_balance > capacity) begin
              cerr_d   = WEM_CE_BAL_OVER;
              done_d   = 1'b1;
              cal_st_d = WEM_CAL_IDLE;
            end
          end
        end
      end
      WEM_CAL_WAIT: begin
        if (adc_valid) begin
          if (stable_indicator) begin
            done_d   = 1'b1;
            cal_st_d = WEM_CAL_IDLE;
            if (!span_q) begin
              if (25'(adc_raw) > WEM_ZERO_MAX) begin
                cerr_d = WEM_CE_ZERO_HIGH;
              end else if (adc_raw < 24'sh000000) begin
                cerr_d = WEM_CE_ZERO_NEG;
              end else begin
                zpt_d = adc_raw;
              end
            end else if (span_v < 25'sh0000000) begin
              cerr_d = WEM_CE_SPAN_NEG;
            end else if (span_v < WEM_SPAN_MIN) begin
              cerr_d = WEM_CE_SPAN_LOW;
            end else if (span_v > WEM_SPAN_MAX) begin
              cerr_d = WEM_CE_SPAN_HIGH;
            end
          end else if (wait_q == WEM_STABLE_INDICATOR_UPD - 8'h01) begin
            cerr_d   = WEM_CE_UNSTABLE;
            done_d   = 1'b1;
            cal_st_d = WEM_CAL_IDLE;
          end else begin
            wait_d = wait_q + 8'h01;
          end
        end
      end
    endcase
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      cal_st_q <= WEM_CAL_IDLE;
      span_q   <= 1'b0;
      wait_q   <= 8'h00;
      cerr_q   <= WEM_CE_NONE;
      done_q   <= 1'b0;
      zpt_q    <= 24'sh000000;
    end else begin
      cal_st_q <= cal_st_d;
      span_q   <= span_d;
      wait_q   <= wait_d;
      cerr_q   <= cerr_d;
      done_q   <= done_d;
      zpt_q    <= zpt_d;
    end
  end

  assign cal_error  = cerr_q;
  assign cal_busy   = cal_st_q == WEM_CAL_WAIT;
  assign cal_done   = done_q;
  assign zero_point = zpt_q;

  // fault flags
  logic exc_q, exc_d;
  logic pend_q, pend_d;
  logic cks_q, cks_d;
  logic mem_q, mem_d;
  logic cks_mis;

  always_comb begin
    cks_mis = cksum_calc != cksum_ref;
    exc_d   = exc_level < WEM_EXC_MIN;
    pend_d  = (pend_q && !cksum_valid) || selfcheck_req;
    cks_d   = (pend_q && cksum_valid) ? cks_mis : cks_q;
    mem_d   = mem_q;
    if (selfcheck_req) begin
      mem_d = 1'b0;
    end
    if (nvm_check_valid && !nvm_check_ok) begin
      mem_d = 1'b1;
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      exc_q  <= 1'b0;
      pend_q <= 1'b1;
      cks_q  <= 1'b0;
      mem_q  <= 1'b0;
    end else begin
      exc_q  <= exc_d;
      pend_q <= pend_d;
      cks_q  <= cks_d;
      mem_q  <= mem_d;
    end
  end

  assign excitation_error = exc_q;
  assign checksum_error   = cks_q;
  assign memory_error     = mem_q;

  // commit scheduling
  logic        ext_seen_q, ext_seen_d;
  logic        lnk_seen_q, lnk_seen_d;
  logic        defer_q, defer_d;
  logic [16:0] ms_q, ms_d;
  logic [16:0] mn_q, mn_d;
  logic        req_q, req_d;
  logic        start_q, start_d;
  logic        imm, later, tick, expire;

  always_comb begin
    imm = chg_panel
      || (chg_ext && !ext_seen_q)
      || (chg_link && !lnk_seen_q);
    later      = (chg_ext && ext_seen_q) || (chg_link && lnk_seen_q);
    ext_seen_d = ext_seen_q || chg_ext;
    lnk_seen_d = lnk_seen_q || chg_link;
    tick       = defer_q && (ms_q == 17'(MS_CYC - 1));
    expire     = tick && (mn_q == 17'(DEFER_MS - 1));
    ms_d       = (!defer_q || tick) ? 17'h00000 : ms_q + 17'h00001;
    mn_d       = mn_q;
    if (!defer_q || expire) begin
      mn_d = 17'h00000;
    end else if (tick) begin
      mn_d = mn_q + 17'h00001;
    end
    defer_d = (defer_q && !expire) || later;
    start_d = req_q && !nvm_write_busy && !start_q;
    req_d   = (req_q && !start_d) || imm || expire;
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      ext_seen_q <= 1'b0;
      lnk_seen_q <= 1'b0;
      defer_q    <= 1'b0;
      ms_q       <= 17'h00000;
      mn_q       <= 17'h00000;
      req_q      <= 1'b0;
      start_q    <= 1'b0;
    end else begin
      ext_seen_q <= ext_seen_d;
      lnk_seen_q <= lnk_seen_d;
      defer_q    <= defer_d;
      ms_q       <= ms_d;
      mn_q       <= mn_d;
      req_q      <= req_d;
      start_q    <= start_d;
    end
  end

  assign nvm_write_start = start_q;
  assign write_pending   = req_q || start_q || nvm_write_busy;

  // checks
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);

  a_gross_over_cmp: assert property (adc_valid |=>
    gross_over_flag == (34'($past(gross_weight)) > WEM_DISP_MAX))
    else $error("gross over flag wrong");
  a_net_over_cmp: assert property (adc_valid |=>
    net_over_flag == ($past(net_w) > WEM_DISP_MAX))
    else $error("net over flag wrong");
  a_cap_over_cmp: assert property (adc_valid |=>
    capacity_over_flag == ($past(gross_w) > $past(cap_lim)))
    else $error("capacity over flag wrong");
  a_flags_hold: assert property (!adc_valid |=> $stable(ovr_q))
    else $error("over flags moved without update");
  a_weight_err_or: assert property (!$past(rst) |-> weight_error ==
    ((|ovr_q) | $past(zero_alarm)))
    else $error("weight error mismatch");
  a_cal_start_clr: assert property ((cal_st_q == WEM_CAL_IDLE && cal_zero_start)
    |=> cal_error == WEM_CE_NONE && cal_busy)
    else $error("calibration start did not clear code");
  a_span_bal_zero: assert property ((cal_st_q == WEM_CAL_IDLE && cal_span_start
    && !cal_zero_start && cal_balance == 17'h00000)
    |=> cal_done && cal_error == WEM_CE_BAL_ZERO)
    else $error("zero balance not reported");
  a_cksum_check: assert property ((pend_q && cksum_valid) |=>
    checksum_error == $past(cks_mis))
    else $error("checksum error wrong");
  a_panel_commit: assert property ((chg_panel && !req_q && !start_q && !nvm_write_busy)
    |=> req_q ##1 nvm_write_start)
    else $error("panel change not committed");
  a_link_defer: assert property ((chg_link && lnk_seen_q && !defer_q && !imm)
    |=> defer_q && !req_q)
    else $error("repeated link change not deferred");
  a_commit_pending: assert property ((imm || expire) |=> write_pending ##1 write_pending)
    else $error("pending dark during commit");

  c_gross_over: cover property (adc_valid ##1 gross_over_flag);
  c_defer_done: cover property (expire ##1 req_q);
  c_cal_unstable: cover property (cal_done && cal_error == WEM_CE_UNSTABLE);
  c_zero_cal_ok: cover property (cal_done && cal_error == WEM_CE_NONE && !span_q);

endmodule

// *** tb/wem_adc_model.sv ***
// load cell converter model: one result per conv call, prompt or slow
// assumes the monitor samples results only while adc_valid is high
module wem_adc_model (
  input  wire logic               mclk,
  output logic                    adc_valid,
  output logic signed      [23:0] adc_raw,
  output logic signed      [31:0] gross_weight,
  output logic signed      [31:0] tare_weight,
  output logic                    stable_indicator
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    adc_valid = 1'b0;
    adc_raw = 24'sh0;
    gross_weight = 32'sh0;
    tare_weight = 32'sh0;
    stable_indicator = 1'b0;
  end
  // gap idles before the update; raw is scrambled once the strobe drops
  task automatic conv(input logic signed [23:0] r, input logic signed [31:0] g,
                      input logic signed [31:0] t, input logic st, input int gap);
    repeat (gap) @(negedge mclk);
    @(negedge mclk);
    adc_valid = 1'b1;
    adc_raw = r;
    gross_weight = g;
    tare_weight = t;
    stable_indicator = st;
    @(negedge mclk);
    adc_valid = 1'b0;
    adc_raw = ~r;
  endtask
endmodule

// *** tb/wem_weigh_error_monitor_tb.sv ***
// bench for the weigh error monitor with a converter model
// assumes short commit timer parameters and inputs driven on falling edges
module wem_weigh_error_monitor_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic mclk, rst, zero_alarm, cal_zero_start, cal_span_start, selfcheck_req, cksum_valid;
  logic nvm_check_valid, nvm_check_ok, chg_panel, chg_ext, chg_link, nvm_write_busy;
  logic [16:0] capacity, cal_balance;
  logic [6:0] scale_div;
  logic [11:0] exc_level;
  logic [15:0] cksum_calc, cksum_ref;
  logic adc_valid, stable_indicator, adc_pos_overload, adc_neg_overload, net_over_flag;
  logic capacity_over_flag, gross_over_flag, weight_error, cal_busy, cal_done;
  logic excitation_error, checksum_error, memory_error, write_pending, nvm_write_start;
  logic signed [23:0] adc_raw, zero_point;
  logic signed [31:0] gross_weight, tare_weight;
  logic [3:0] cal_error;
  logic done_seen;
  int fails, n_tests;
  wem_adc_model wem_adc_model_i (.mclk, .adc_valid, .adc_raw, .gross_weight, .tare_weight,
    .stable_indicator);
  wem_weigh_error_monitor #(.MS_CYC(4), .DEFER_MS(3)) wem_weigh_error_monitor_i (.mclk, .rst,
    .adc_valid, .adc_raw, .gross_weight, .tare_weight, .capacity, .scale_div, .zero_alarm,
    .stable_indicator, .cal_zero_start, .cal_span_start, .cal_balance, .exc_level,
    .selfcheck_req, .cksum_valid, .cksum_calc, .cksum_ref, .nvm_check_valid, .nvm_check_ok,
    .chg_panel, .chg_ext, .chg_link, .nvm_write_busy, .adc_pos_overload, .adc_neg_overload,
    .net_over_flag, .capacity_over_flag, .gross_over_flag, .weight_error, .cal_error,
    .cal_busy, .cal_done, .zero_point, .excitation_error, .checksum_error, .memory_error,
    .write_pending, .nvm_write_start);
  always #5 mclk = ~mclk;
  always @(posedge mclk) begin
    if (cal_done === 1'b1) done_seen = 1'b1;
  end
  task automatic tally_and_finish();
    if (fails == 0 && n_tests > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [47:0] e, input logic [47:0] s);
    n_tests++;
    if (s !== e) begin
      fails++;
      $display("BAD %s expected %h seen %h", nm, e, s);
    end
  endtask
  task automatic give_up(input string nm);
    chk(nm, 48'h1, 48'h0);
    tally_and_finish();
  endtask
  // one update, then flags {pos, neg, net, cap, gross, error} one cycle on
  task automatic ov(input logic signed [23:0] r, input logic signed [31:0] g,
                    input logic signed [31:0] t, input logic [5:0] e);
    wem_adc_model_i.conv(r, g, t, 1'b1, 0);
    @(negedge mclk);
    chk("flags", {42'h0, e}, {42'h0, adc_pos_overload, adc_neg_overload, net_over_flag,
        capacity_over_flag, gross_over_flag, weight_error});
  endtask
  task automatic pl(input int k);
    case (k)
      0: cksum_valid = 1'b1;
      1: selfcheck_req = 1'b1;
      default: nvm_check_valid = 1'b1;
    endcase
    @(negedge mclk);
    {cksum_valid, selfcheck_req, nvm_check_valid} = 3'b000;
    @(negedge mclk);
  endtask
  // im: refused at once without waiting for a stable update
  task automatic cal(input logic span, input logic [16:0] bal, input logic signed [23:0] r,
                     input logic st, input logic im, input logic [3:0] e);
    int n;
    n = 0;
    done_seen = 1'b0;
    cal_balance = bal;
    if (span) cal_span_start = 1'b1;
    else cal_zero_start = 1'b1;
    @(negedge mclk);
    {cal_span_start, cal_zero_start} = 2'b00;
    @(negedge mclk);
    if (!im) begin
      chk("cleared", 48'h0, {44'h0, cal_error});
      chk("busy", 48'h1, {47'h0, cal_busy});
    end
    while (!done_seen && n < 300) begin
      wem_adc_model_i.conv(r, 32'sh0, 32'sh0, st, n % 2);
      n++;
    end
    if (!done_seen) give_up("cal_done");
    chk("code", {44'h0, e}, {44'h0, cal_error});
    chk("idle", 48'h0, {47'h0, cal_busy});
  endtask
  // counts falling edges from the change to the write start
  task automatic commit(input int k, input int lo, input int hi);
    int n;
    n = 0;
    case (k)
      0: chg_panel = 1'b1;
      1: chg_ext = 1'b1;
      default: chg_link = 1'b1;
    endcase
    @(negedge mclk);
    {chg_panel, chg_ext, chg_link} = 3'b000;
    while (nvm_write_start !== 1'b1 && n < 40) begin
      @(negedge mclk);
      n++;
    end
    if (n >= 40) give_up("write_start");
    chk("delay", 48'h1, {47'h0, n >= lo && n <= hi});
    nvm_write_busy = 1'b1;
    repeat (3) begin
      @(negedge mclk);
      chk("pending", 48'h1, {47'h0, write_pending});
    end
    nvm_write_busy = 1'b0;
    repeat (2) @(negedge mclk);
    chk("pending", 48'h0, {47'h0, write_pending});
  endtask
  initial begin
    {mclk, rst, zero_alarm, cal_zero_start, cal_span_start, selfcheck_req} = 6'b010000;
    {cksum_valid, nvm_check_valid, nvm_check_ok, chg_panel, chg_ext, chg_link} = 6'b001000;
    {nvm_write_busy, cksum_calc, cksum_ref, exc_level} = {1'b0, 16'h1, 16'h2, 12'hfff};
    {capacity, scale_div, cal_balance} = {17'h3e8, 7'ha, 17'h0};
    {fails, n_tests, done_seen} = 0;
    repeat (5) @(negedge mclk);
    chk("reset", 48'h0, {7'h0, adc_pos_overload, adc_neg_overload, net_over_flag,
        weight_error, cal_error, cal_busy, cal_done, zero_point, checksum_error, memory_error,
        write_pending, nvm_write_start, excitation_error, capacity_over_flag, gross_over_flag});
    rst = 1'b0;
    @(negedge mclk);
    ov(24'sh100, 32'sd1090, 32'sd1090, 6'b000000);
    ov(24'sh100, 32'sd1091, 32'sd1091, 6'b000101);
    capacity = 17'h1ffff;
    ov(24'sh100, 32'sd100000, 32'sd1, 6'b000011);
    ov(24'sh100, 32'sd99999, -32'sd1, 6'b001001);
    ov(24'sh100, 32'sd99999, 32'sd0, 6'b000000);
    ov(24'sh7fff01, 32'sd0, 32'sd0, 6'b100001);
    ov(24'sh7fff00, 32'sd0, 32'sd0, 6'b000000);
    ov(24'sh8000ff, 32'sd0, 32'sd0, 6'b010001);
    ov(24'sh800100, 32'sd0, 32'sd0, 6'b000000);
    zero_alarm = 1'b1;
    ov(24'sh100, 32'sd0, 32'sd0, 6'b000001);
    zero_alarm = 1'b0;
    capacity = 17'h3e8;
    cal(1'b0, 17'h0, 24'sh200001, 1'b1, 1'b0, 4'h2);
    cal(1'b0, 17'h0, -24'sh1, 1'b1, 1'b0, 4'h3);
    cal(1'b0, 17'h0, 24'sh1000, 1'b1, 1'b0, 4'h0);
    chk("zero_point", 48'h1000, {24'h0, zero_point});
    cal(1'b1, 17'h3e9, 24'sh1000, 1'b1, 1'b1, 4'h4);
    cal(1'b1, 17'h0, 24'sh1000, 1'b1, 1'b1, 4'h5);
    cal(1'b1, 17'h258, 24'sh1010, 1'b1, 1'b0, 4'h6);
    cal(1'b1, 17'h258, 24'sh0ff0, 1'b1, 1'b0, 4'h7);
    cal(1'b1, 17'h258, 24'sh201001, 1'b1, 1'b0, 4'h8);
    cal(1'b1, 17'h258, 24'sh101000, 1'b1, 1'b0, 4'h0);
    cal(1'b0, 17'h0, 24'sh1000, 1'b0, 1'b0, 4'h9);
    exc_level = 12'h7ff;
    repeat (2) @(negedge mclk);
    chk("exc", 48'h1, {47'h0, excitation_error});
    exc_level = 12'h800;
    repeat (2) @(negedge mclk);
    chk("exc", 48'h0, {47'h0, excitation_error});
    pl(0);
    chk("cksum", 48'h1, {47'h0, checksum_error});
    pl(1);
    cksum_ref = 16'h1;
    pl(0);
    chk("cksum", 48'h0, {47'h0, checksum_error});
    cksum_ref = 16'h3;
    pl(0);
    chk("cksum", 48'h0, {47'h0, checksum_error});
    nvm_check_ok = 1'b0;
    pl(2);
    chk("mem", 48'h1, {47'h0, memory_error});
    nvm_check_ok = 1'b1;
    pl(1);
    pl(2);
    chk("mem", 48'h0, {47'h0, memory_error});
    commit(0, 1, 1);
    commit(0, 1, 1);
    commit(1, 1, 1);
    commit(2, 1, 1);
    commit(1, 13, 13);
    commit(2, 13, 13);
    tally_and_finish();
  end
endmodule
